// ===== rtl/supply_fault_status_log.sv
// Top of the supply fault status and logging register bank.
// Assumes a serial-bus engine outside presents byte reads and writes on a pointer port.
//
// How it works
// - Detector status bits mirror seven supply faults.
// - Watchdog timeout shows on status bit four.
// - General input levels show on bits three-zero.
// - Outputs one to eight show on low status.
// - Output nine on bit zero, rest reserved.
// - Any-fault flag marks a logged change.
// - Supply log bits record the seven detectors.
// - Input log bit four records watchdog changes.
// - Input log low bits record input changes.
// - Supply mask bits stop supply logging.
// - Input mask stops watchdog and input logging.
// - Every register powers up as zero.
// - Set flag freezes both logs until input log read.
// - Reading input log clears the flag.
// - Flag is unmaskable; masked bits stay zero.
`include "supply_fault_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module supply_fault_status_log (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Register pointer port.
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  // Monitored functions.
  input  wire logic [6:0] i_supply_fault,
  input  wire logic       i_watchdog_timeout,
  input  wire logic [3:0] i_general_input,
  input  wire logic [8:0] i_output_level,
  // Fault plane flag for system use.
  output logic            o_any_fault_flag
);
  supply_fault_pkg::top_state_t st_q, st_d; // Port state and its next value.
  logic [7:0] read_value;                   // Byte selected by the pointer.
  logic       hit_supply_mask;              // Pointer selects the supply mask.
  logic       hit_input_mask;               // Pointer selects the input mask.
  logic       hit_input_log;                // Pointer selects the input fault log.

  fault_link_if link (); // Carrier between the port and the two helpers.

  // The sampler registers the live levels once, so every register and the
  // plane see the same copy of a level in a given cycle.
  level_sampler u_sampler (
    .i_clk              (i_clk),
    .i_rst_n            (i_rst_n),
    .i_supply_fault     (i_supply_fault),
    .i_watchdog_timeout (i_watchdog_timeout),
    .i_general_input    (i_general_input),
    .i_output_level     (i_output_level),
    .link               (link)
  );

  // The plane owns the logged bits and the latched flag.
  fault_plane u_plane (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .link    (link)
  );

  // Address decode for the registers with side effects.
  assign hit_supply_mask = (i_reg_addr == `OFS_SUPPLY_FAULT_MASK);
  assign hit_input_mask  = (i_reg_addr == `OFS_INPUT_FAULT_MASK);
  assign hit_input_log   = (i_reg_addr == `OFS_INPUT_FAULT_LOG);

  // Reading the input fault log releases the plane. The read data is taken in
  // the same edge, so the host still sees the frozen contents it is clearing.
  // The host is expected to read this only after seeing the flag set, because
  // a read without that check can wipe a change it never saw.
  assign link.log_clear = i_reg_rd && hit_input_log;

  // The masks live here because software writes them; the plane reads them.
  assign link.supply_mask = st_q.supply_mask;
  assign link.input_mask  = st_q.input_mask;

  // Readback multiplexer. Unmapped pointers read zero so the bus engine always
  // has a defined byte to return.
  always_comb begin
    read_value = `REG_RESET_VALUE;
    unique case (i_reg_addr)
      `OFS_SUPPLY_FAULT_MASK: begin
        read_value = {1'b0, st_q.supply_mask};
      end
      `OFS_INPUT_FAULT_MASK: begin
        read_value = {3'h0, st_q.input_mask};
      end
      `OFS_DETECTOR_FAULT_STATUS: begin
        read_value = {1'b0, link.supply_level};
      end
      `OFS_INPUT_WATCHDOG_STATUS: begin
        read_value = {3'h0, link.watchdog_level, link.input_level};
      end
      `OFS_SUPPLY_FAULT_LOG: begin
        read_value = {link.any_fault_flag, link.supply_log};
      end
      `OFS_INPUT_FAULT_LOG: begin
        read_value = {3'h0, link.input_log};
      end
      `OFS_OUTPUT_LEVEL_STATUS_LOW: begin
        read_value = link.output_level[7:0];
      end
      `OFS_OUTPUT_LEVEL_STATUS_HIGH: begin
        read_value = {7'h00, link.output_level[8]};
      end
      default: begin
        // Any other pointer value is outside this bank.
        read_value = `REG_RESET_VALUE;
      end
    endcase
  end

  // Next state of the port: mask writes keep only the defined bits, and the
  // read byte is captured whenever a read is requested.
  always_comb begin
    st_d        = st_q;
    st_d.rvalid = i_reg_rd;
    if (i_reg_wr && hit_supply_mask) begin
      st_d.supply_mask = i_reg_wdata[6:0];
    end
    if (i_reg_wr && hit_input_mask) begin
      st_d.input_mask = i_reg_wdata[4:0];
    end
    if (i_reg_rd) begin
      st_d.rdata = read_value;
    end
  end

  // Power-on state is all zeros for masks and read data alike.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from flip-flops.
  assign o_reg_rdata      = st_q.rdata;
  assign o_reg_rvalid     = st_q.rvalid;
  assign o_any_fault_flag = link.any_fault_flag;

  // Checks on the bank, all on the one clock; all but reset_zero_a are disabled in reset.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // A detector level reaches the status register one cycle after the pin.
  detector_level_a: assert property (
    (i_reg_rd && i_reg_addr == `OFS_DETECTOR_FAULT_STATUS)
      |=> (o_reg_rdata == {1'b0, $past(link.supply_level)}) && o_reg_rvalid
  ) else $error("detector status readback wrong");

  // The sampled detector level follows the input with one cycle delay.
  detector_track_a: assert property (
    ##1 (link.supply_level == $past(i_supply_fault))
  ) else $error("detector level not tracking input");

  // Watchdog timeout shows on bit four, reserved bits zero.
  watchdog_status_a: assert property (
    (i_reg_rd && i_reg_addr == `OFS_INPUT_WATCHDOG_STATUS)
      |=> (o_reg_rdata[`POS_WATCHDOG] == $past(i_watchdog_timeout, 2))
          && (o_reg_rdata[7:5] == 3'h0)
  ) else $error("watchdog status bit wrong");

  // General inputs show on the low nibble two cycles after the pins.
  input_level_a: assert property (
    (i_reg_rd && i_reg_addr == `OFS_INPUT_WATCHDOG_STATUS)
      |=> (o_reg_rdata[3:0] == $past(i_general_input, 2))
  ) else $error("general input status wrong");

  // Outputs one to eight on the low output status register.
  output_low_a: assert property (
    (i_reg_rd && i_reg_addr == `OFS_OUTPUT_LEVEL_STATUS_LOW)
      |=> (o_reg_rdata == $past(i_output_level[7:0], 2))
  ) else $error("low output status wrong");

  // Output nine on bit zero, the rest of the byte is zero.
  output_high_a: assert property (
    (i_reg_rd && i_reg_addr == `OFS_OUTPUT_LEVEL_STATUS_HIGH)
      |=> (o_reg_rdata == {7'h00, $past(i_output_level[8], 2)})
  ) else $error("high output status wrong");

  // A new unmasked detector level raises the flag and is logged at once.
  flag_raise_a: assert property (
    (!link.any_fault_flag
      && (((link.supply_level ^ link.supply_log) & ~link.supply_mask) != 7'h00))
      |=> link.any_fault_flag
          && (link.supply_log == $past(link.supply_level & ~link.supply_mask))
  ) else $error("supply change not logged");

  // With no change and no flag, the flag stays low.
  flag_quiet_a: assert property (
    (!link.any_fault_flag
      && (((link.supply_level ^ link.supply_log) & ~link.supply_mask) == 7'h00)
      && ((({link.watchdog_level, link.input_level} ^ link.input_log)
           & ~link.input_mask) == 5'h00))
      |=> !link.any_fault_flag
  ) else $error("flag raised without a change");

  // A watchdog change lands in input log bit four.
  watchdog_log_a: assert property (
    (!link.any_fault_flag && !link.input_mask[4]
      && (link.watchdog_level != link.input_log[4]))
      |=> link.any_fault_flag && (link.input_log[4] == $past(link.watchdog_level))
  ) else $error("watchdog change not logged");

  // A general input change lands in the low input log bits.
  input_log_a: assert property (
    (!link.any_fault_flag && (link.input_mask[3:0] == 4'h0)
      && (link.input_level != link.input_log[3:0]))
      |=> link.any_fault_flag && (link.input_log[3:0] == $past(link.input_level))
  ) else $error("input change not logged");

  // Once set, the log holds steady until released, while masks stay put.
  // The masks must be settled in the checked cycle, since a fresh mask bit
  // forces its frozen log bit to zero on the following edge.
  log_freeze_a: assert property (
    (link.any_fault_flag && !link.log_clear
      && $stable(link.supply_mask) && $stable(link.input_mask))
      |=> $stable(link.supply_log) && $stable(link.input_log) && link.any_fault_flag
  ) else $error("fault log moved while latched");

  // Reading the input log drops the flag on the next edge.
  read_clear_a: assert property (
    (link.any_fault_flag && i_reg_rd && hit_input_log) |=> !link.any_fault_flag
  ) else $error("input log read did not clear flag");

  // Reading the supply log has no clearing effect.
  supply_read_a: assert property (
    (link.any_fault_flag && i_reg_rd && i_reg_addr == `OFS_SUPPLY_FAULT_LOG)
      |=> link.any_fault_flag && o_reg_rdata[`POS_ANY_FAULT_FLAG]
  ) else $error("supply log read disturbed flag");

  // Masked supply bits read as zero once the mask has settled.
  supply_masked_a: assert property (
    ($stable(link.supply_mask)) |-> ((link.supply_log & link.supply_mask) == 7'h00)
  ) else $error("masked supply bit logged");

  // Masked input bits read as zero once the mask has settled.
  input_masked_a: assert property (
    ($stable(link.input_mask)) |-> ((link.input_log & link.input_mask) == 5'h00)
  ) else $error("masked input bit logged");

  // A mask write stores only the defined bits, reserved ones read zero.
  mask_write_a: assert property (
    (i_reg_wr && hit_supply_mask && !i_reg_rd)
      ##1 (i_reg_rd && hit_supply_mask && !i_reg_wr)
      |=> (o_reg_rdata == {1'b0, $past(i_reg_wdata[6:0], 2)})
  ) else $error("supply mask readback wrong");

  // Reset leaves every register and the flag at zero.
  reset_zero_a: assert property (
    disable iff (1'b0)
    (!i_rst_n) |=> (st_q == '0) && !link.any_fault_flag
                   && (link.supply_log == 7'h00) && (link.input_log == 5'h00)
  ) else $error("register not zero after reset");
endmodule : supply_fault_status_log
`default_nettype wire

// ===== rtl/supply_fault_regs.svh
// Register offsets, bit positions and reset values of the supply fault status bank.
// Assumes byte-wide registers reached through an eight-bit register pointer.
`ifndef SUPPLY_FAULT_REGS_SVH
`define SUPPLY_FAULT_REGS_SVH
// Register offsets.
`define OFS_SUPPLY_FAULT_MASK        8'h9d
`define OFS_INPUT_FAULT_MASK         8'h9e
`define OFS_DETECTOR_FAULT_STATUS    8'hda
`define OFS_INPUT_WATCHDOG_STATUS    8'hdb
`define OFS_SUPPLY_FAULT_LOG         8'hdc
`define OFS_INPUT_FAULT_LOG          8'hdd
`define OFS_OUTPUT_LEVEL_STATUS_LOW  8'hde
`define OFS_OUTPUT_LEVEL_STATUS_HIGH 8'hdf
// Field positions.
`define POS_ANY_FAULT_FLAG           7
`define POS_WATCHDOG                 4
// Power-on value of every register in the bank.
`define REG_RESET_VALUE              8'h00
`endif

// ===== rtl/supply_fault_pkg.sv
// Types shared by the supply fault status bank modules.
// Assumes the offsets and bit positions come from supply_fault_regs.svh.
package supply_fault_pkg;
  // Sampled levels of every monitored function.
  typedef struct packed {
    logic [6:0] supply_level;   // Supply detector outputs.
    logic       watchdog_level; // Watchdog timeout status.
    logic [3:0] input_level;    // General input levels.
    logic [8:0] output_level;   // Programmable output levels.
  } sampler_state_t;
  // Fault plane contents.
  typedef struct packed {
    logic       any_fault_flag; // Latches the plane once set.
    logic [6:0] supply_log;     // Logged supply detector outputs.
    logic [4:0] input_log;      // Logged watchdog and general inputs.
  } plane_state_t;
  // Register port state of the top module.
  typedef struct packed {
    logic [6:0] supply_mask;    // Supply logging mask.
    logic [4:0] input_mask;     // Watchdog and input logging mask.
    logic [7:0] rdata;          // Registered read data.
    logic       rvalid;         // Read answer strobe.
  } top_state_t;
endpackage : supply_fault_pkg

// ===== rtl/fault_link_if.sv
// Signals passed between the level sampler, the fault plane and the register port.
// Assumes all three parties share one clock.
`timescale 1ns/1ps
`default_nettype none
interface fault_link_if;
  logic [6:0] supply_level;   // Registered supply detector outputs.
  logic       watchdog_level; // Registered watchdog timeout status.
  logic [3:0] input_level;    // Registered general input levels.
  logic [8:0] output_level;   // Registered programmable output levels.
  logic [6:0] supply_mask;    // Supply mask from the register port.
  logic [4:0] input_mask;     // Watchdog and input mask from the register port.
  logic       log_clear;      // One-cycle pulse on a read of the input fault log.
  logic       any_fault_flag; // Fault plane latched flag.
  logic [6:0] supply_log;     // Fault plane supply bits.
  logic [4:0] input_log;      // Fault plane watchdog and input bits.
  // The sampler produces the levels.
  modport sampler (output supply_level, watchdog_level, input_level, output_level);
  // The plane consumes levels and masks and returns the log.
  modport plane (input supply_level, watchdog_level, input_level, supply_mask,
                 input_mask, log_clear, output any_fault_flag, supply_log, input_log);
  // The register port reads everything and drives masks and the clear.
  modport port (input supply_level, watchdog_level, input_level, output_level,
                any_fault_flag, supply_log, input_log,
                output supply_mask, input_mask, log_clear);
endinterface : fault_link_if
`default_nettype wire

// ===== rtl/level_sampler.sv
// Registers the live levels of detectors, watchdog, inputs and outputs.
// Assumes every input is already synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module level_sampler (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Live levels.
  input  wire logic [6:0] i_supply_fault,
  input  wire logic       i_watchdog_timeout,
  input  wire logic [3:0] i_general_input,
  input  wire logic [8:0] i_output_level,
  // Registered levels.
  fault_link_if.sampler   link
);
  supply_fault_pkg::sampler_state_t st_q, st_d; // Sampled levels and their next value.

  // Every status bit simply follows its source one cycle later.
  always_comb begin
    st_d = '{supply_level: i_supply_fault, watchdog_level: i_watchdog_timeout,
             input_level: i_general_input, output_level: i_output_level};
  end

  // Power-on value is all zeros.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.supply_level   = st_q.supply_level;
  assign link.watchdog_level = st_q.watchdog_level;
  assign link.input_level    = st_q.input_level;
  assign link.output_level   = st_q.output_level;
endmodule : level_sampler
`default_nettype wire

// ===== rtl/fault_plane.sv
// Fault plane: logs changes of the twelve monitored functions under one latched flag.
// Assumes masks and the clear pulse come from the register port on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fault_plane (
  // Clock and reset.
  input  wire logic     i_clk,
  input  wire logic     i_rst_n,
  // Levels, masks, clear and log.
  fault_link_if.plane   link
);
  supply_fault_pkg::plane_state_t st_q, st_d; // Plane contents and their next value.
  logic [6:0] cur_supply;                     // Masked live supply levels.
  logic [4:0] cur_input;                      // Masked live watchdog and input levels.
  logic       changed;                        // Some unmasked bit differs from the log.

  // While the flag is low the log tracks the masked levels and any difference
  // raises the flag; once high the log is frozen so the first change stays visible.
  // A change that lands in the clearing cycle is caught one cycle later, since the
  // frozen log still differs from the live level; nothing is lost.
  always_comb begin
    st_d       = st_q;
    cur_supply = link.supply_level & ~link.supply_mask;
    cur_input  = {link.watchdog_level, link.input_level} & ~link.input_mask;
    changed    = |((cur_supply ^ st_q.supply_log) & ~link.supply_mask) |
                 |((cur_input ^ st_q.input_log) & ~link.input_mask);
    if (st_q.any_fault_flag) begin
      // Frozen, but masked bits are still held at zero.
      st_d.supply_log = st_q.supply_log & ~link.supply_mask;
      st_d.input_log  = st_q.input_log & ~link.input_mask;
      if (link.log_clear) begin
        st_d.any_fault_flag = 1'b0;
      end
    end else begin
      st_d.supply_log     = cur_supply;
      st_d.input_log      = cur_input;
      st_d.any_fault_flag = changed;
    end
  end

  // Power-on value is all zeros.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.any_fault_flag = st_q.any_fault_flag;
  assign link.supply_log     = st_q.supply_log;
  assign link.input_log      = st_q.input_log;
endmodule : fault_plane
`default_nettype wire

// ===== verification/host_model.sv
// Host model: a supervising processor on the register pointer port.
// Assumes the bench calls its tasks; requests change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and answer.
  input  wire logic       i_clk,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_rvalid,
  // Request.
  output var  logic [7:0] o_reg_addr,
  output var  logic       o_reg_wr,
  output var  logic [7:0] o_reg_wdata,
  output var  logic       o_reg_rd
);
  // Strobes idle low from time zero so nothing is taken early.
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd    = 1'b0;
  end
  // One byte written; the strobe stands for exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr    = 1'b1;
    @(negedge i_clk);
    o_reg_wr    = 1'b0;
    // Released lines flip so a stale value is never mistaken for a live one.
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
  endtask : wr
  // One byte read; the answer is awaited for a bounded number of cycles.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d  = 8'h00;
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_rd   = 1'b1;
    @(negedge i_clk);
    o_reg_rd   = 1'b0;
    o_reg_addr = ~a;
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_reg_rvalid === 1'b1) begin
        d  = i_reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge i_clk);
      end
    end
  endtask : rd
  // A write followed at once by a read of the same place, back to back.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                       output logic ok);
    int n;
    ok = 1'b0;
    q  = 8'h00;
    @(negedge i_clk);
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr    = 1'b1;
    @(negedge i_clk);
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b1;
    @(negedge i_clk);
    o_reg_rd    = 1'b0;
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_reg_rvalid === 1'b1) begin
        q  = i_reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge i_clk);
      end
    end
  endtask : wr_rd
endmodule : host_model
`default_nettype wire

// ===== verification/supply_fault_status_log_tb_top.sv
// Self-checking bench for the supply fault status and logging bank.
// Assumes the host model drives the register port; pins change on falling edges.
`include "supply_fault_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module supply_fault_status_log_tb_top;
  logic       i_clk;      // 200 MHz clock.
  logic       i_rst_n;    // Synchronous reset, active low.
  logic [7:0] addr;       // Register pointer.
  logic       wr;         // Write strobe.
  logic [7:0] wdata;      // Write byte.
  logic       rd;         // Read strobe.
  logic [7:0] rdata;      // Read byte.
  logic       rvalid;     // Read answer strobe.
  logic [6:0] sup;        // Supply detector pins.
  logic       wdog;       // Watchdog timeout pin.
  logic [3:0] gin;        // General input pins.
  logic [8:0] outs;       // Output level pins.
  logic       flag;       // Any-fault flag pin.
  int         failures;   // Mismatch count.
  int         checked;    // Comparison count.
  // Clock, 5 ns period.
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  host_model i_host_model (.i_clk(i_clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
    .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_wdata(wdata), .o_reg_rd(rd));
  supply_fault_status_log i_supply_fault_status_log (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_supply_fault(sup),
    .i_watchdog_timeout(wdog), .i_general_input(gin), .i_output_level(outs),
    .o_any_fault_flag(flag));
  // Verdict and end of run, reached from the main sequence or a hang.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // Compare a seen value with an expected one.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Read and compare; a read that is never answered ends the run.
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host_model.rd(a, d, ok);
    if (!ok) begin
      failures++;
      end_of_test();
    end else begin
      chk(d, exp);
    end
  endtask : rc
  // Write and read back in consecutive cycles, then compare.
  task automatic wrc(input logic [7:0] a, input logic [7:0] v, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host_model.wr_rd(a, v, d, ok);
    if (!ok) begin
      failures++;
      end_of_test();
    end else begin
      chk(d, exp);
    end
  endtask : wrc
  // Set the pins, then allow for sampling and logging before reads.
  task automatic pins(input logic [6:0] s, input logic w, input logic [3:0] g,
                      input logic [8:0] o);
    @(negedge i_clk);
    sup  = s;
    wdog = w;
    gin  = g;
    outs = o;
    repeat (3) @(negedge i_clk);
  endtask : pins
  // A hang is cut short and counted.
  initial begin
    repeat (5000) @(posedge i_clk);
    failures++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    int i;
    logic [7:0] regs [8];
    regs = '{`OFS_SUPPLY_FAULT_MASK, `OFS_INPUT_FAULT_MASK, `OFS_DETECTOR_FAULT_STATUS,
             `OFS_INPUT_WATCHDOG_STATUS, `OFS_SUPPLY_FAULT_LOG, `OFS_INPUT_FAULT_LOG,
             `OFS_OUTPUT_LEVEL_STATUS_LOW, `OFS_OUTPUT_LEVEL_STATUS_HIGH};
    failures = 0;
    checked  = 0;
    i_rst_n  = 1'b0;
    sup      = 7'h00;
    wdog     = 1'b0;
    gin      = 4'h0;
    outs     = 9'h000;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    // Every register powers up as zero; an unmapped place reads zero.
    for (i = 0; i < 8; i++) begin
      rc(regs[i], `REG_RESET_VALUE);
    end
    rc(8'h90, 8'h00);
    $display("test reset done");
    // Status mirrors and the first logged change of many functions at once.
    pins(7'h55, 1'b1, 4'ha, 9'h1a5);
    rc(`OFS_DETECTOR_FAULT_STATUS, 8'h55);
    rc(`OFS_INPUT_WATCHDOG_STATUS, 8'h1a);
    rc(`OFS_OUTPUT_LEVEL_STATUS_LOW, 8'ha5);
    rc(`OFS_OUTPUT_LEVEL_STATUS_HIGH, 8'h01);
    chk({7'h00, flag}, 8'h01);
    rc(`OFS_SUPPLY_FAULT_LOG, 8'hd5);
    rc(`OFS_INPUT_FAULT_LOG, 8'h1a);
    rc(`OFS_SUPPLY_FAULT_LOG, 8'h55);
    $display("test status done");
    // A second change while flagged stays out of the log until it is read.
    pins(7'h54, 1'b1, 4'ha, 9'h1a5);
    pins(7'h54, 1'b1, 4'hb, 9'h1a5);
    rc(`OFS_SUPPLY_FAULT_LOG, 8'hd4);
    rc(`OFS_INPUT_FAULT_LOG, 8'h1a);
    rc(`OFS_SUPPLY_FAULT_LOG, 8'hd4);
    rc(`OFS_INPUT_FAULT_LOG, 8'h1b);
    rc(`OFS_SUPPLY_FAULT_LOG, 8'h54);
    $display("test freeze done");
    // Masks keep reserved bits zero and silence logging; writes elsewhere drop.
    wrc(`OFS_SUPPLY_FAULT_MASK, 8'hff, 8'h7f);
    i_host_model.wr(`OFS_INPUT_FAULT_MASK, 8'hff);
    rc(`OFS_INPUT_FAULT_MASK, 8'h1f);
    i_host_model.wr(`OFS_DETECTOR_FAULT_STATUS, 8'hff);
    rc(`OFS_DETECTOR_FAULT_STATUS, 8'h54);
    i_host_model.wr(8'h90, 8'h5a);
    rc(8'h90, 8'h00);
    pins(7'h00, 1'b0, 4'h0, 9'h000);
    rc(`OFS_SUPPLY_FAULT_LOG, 8'h00);
    chk({7'h00, flag}, 8'h00);
    i_host_model.wr(`OFS_SUPPLY_FAULT_MASK, 8'h00);
    i_host_model.wr(`OFS_INPUT_FAULT_MASK, 8'h00);
    pins(7'h08, 1'b0, 4'h0, 9'h000);
    rc(`OFS_SUPPLY_FAULT_LOG, 8'h88);
    rc(`OFS_INPUT_FAULT_LOG, 8'h00);
    $display("test masks done");
    end_of_test();
  end
endmodule : supply_fault_status_log_tb_top
`default_nettype wire
